// file: pic_pkg.sv
// Summary of operation
// - Thresholds are compared with the IR or the proximity reading as the mode selects.
// - A mode change clears the persistence counter.
// - The LED is driven steadily or as a 360 kHz half-duty square wave per bit 6.
// - Bits 5 and 4 of the second command register pick one of four LED currents.
// - A detection cycle runs three sensing phases one after another.
// - The LED is on only in the proximity phase.
// - The device answers at a fixed 7-bit address that cannot be changed.
// - The flag sets after m consecutive out-of-window cycles, m from the persist field; a single-shot cycle's return to power-down clears the count.
// - The flag holds until a first command register write completes without a threshold event in the same cycle, then clears.
// - Mode codes 000, 010, 011, 110 and 111 are valid; the rest are reserved.
// - Low threshold resets to zero at 04/05, high threshold to all ones at 06/07.
package pic_pkg;
   localparam int unsigned ADDR_W   = 8;
   localparam logic [5:0] IDX_CMD1  = 6'h00;
   localparam logic [5:0] IDX_CMD2  = 6'h01;
   localparam logic [5:0] IDX_DLSB  = 6'h02;
   localparam logic [5:0] IDX_DMSB  = 6'h03;
   localparam logic [5:0] IDX_LTL   = 6'h04;
   localparam logic [5:0] IDX_LTM   = 6'h05;
   localparam logic [5:0] IDX_HTL   = 6'h06;
   localparam logic [5:0] IDX_HTM   = 6'h07;
   localparam logic [5:0] IDX_STAT  = 6'h08;
   localparam logic [5:0] IDX_CLR   = 6'h09;
   localparam logic [5:0] IDX_EN    = 6'h0A;
   localparam logic [5:0] IDX_ADDR  = 6'h0B;
   localparam logic [7:0] RST_LT    = 8'h00;
   localparam logic [7:0] RST_HT    = 8'hFF;
   localparam logic [6:0] BUS_ADDR  = 7'h44;
   localparam logic [2:0] MODE_OFF  = 3'h0;
   localparam logic [2:0] MODE_IR1  = 3'h2;
   localparam logic [2:0] MODE_PX1  = 3'h3;
   localparam logic [2:0] MODE_IRC  = 3'h6;
   localparam logic [2:0] MODE_PXC  = 3'h7;
   localparam logic [4:0] PERS_1    = 5'h01;
   localparam logic [4:0] PERS_4    = 5'h04;
   localparam logic [4:0] PERS_8    = 5'h08;
   localparam logic [4:0] PERS_16   = 5'h10;
   localparam logic [15:0] LEN_16   = 16'hFFFF;
   localparam logic [15:0] LEN_12   = 16'h0FFF;
   localparam logic [15:0] LEN_8    = 16'h00FF;
   localparam logic [15:0] LEN_4    = 16'h000F;
   localparam int unsigned CLK_KHZ  = 125000;
   localparam int unsigned MOD_KHZ  = 360;
   localparam logic [7:0] MOD_HALF  = 8'(CLK_KHZ / (2 * MOD_KHZ) - 1);
   localparam int unsigned STAT_THR = 0;
   localparam int unsigned STAT_DONE = 1;
   localparam logic [1:0] RESP_OK   = 2'h0;
   localparam logic [1:0] RESP_ERR  = 2'h2;
   typedef struct packed {
      logic [2:0] mode;
      logic [1:0] rsvd;
      logic       flag;
      logic [1:0] persist;
   } pic_cmd1_t;
   typedef struct packed {
      logic       scheme;
      logic       mod_en;
      logic [1:0] current;
      logic [1:0] res;
      logic [1:0] range;
   } pic_cmd2_t;
   typedef enum logic [3:0] {
      SEQ_IDLE = 4'b0001,
      SEQ_IR1  = 4'b0010,
      SEQ_PROX = 4'b0100,
      SEQ_IR2  = 4'b1000
   } pic_seq_t;
endpackage

// file: pic_top.sv
module pic_top (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        ce,
   input  wire logic [7:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [7:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   input  wire logic        osc_clk,
   input  wire logic [15:0] adc_code,
   output logic             led_drive_output,
   output logic [1:0]       led_current_sel,
   output logic [1:0]       adc_resolution,
   output logic [1:0]       adc_range,
   output logic             adc_integrate,
   output logic             adc_prox_phase,
   output logic             int_n_o,
   output logic             int_n_oe,
   output logic             irq
);
   logic              aw_hold, w_hold, w_lane, bvalid_q, rvalid_q;
   logic              next_aw_hold, next_w_hold, next_w_lane, next_bvalid, next_rvalid;
   logic [5:0]        aw_idx, next_aw_idx, rd_idx, next_rd_idx;
   logic [7:0]        w_byte, next_w_byte, rd_val;
   logic [1:0]        bresp_q, next_bresp, rresp_q, next_rresp;
   logic [31:0]       rdata_q, next_rdata;
   logic              wr_do, wr_ok, wr_cmd1, mode_wr_chg;
   pic_pkg::pic_cmd1_t cmd1, next_cmd1;
   pic_pkg::pic_cmd2_t cmd2, next_cmd2;
   logic [15:0]       lt, next_lt, ht, next_ht, data, next_data;
   logic [1:0]        stat, next_stat, en, next_en;
   logic [4:0]        pcnt, next_pcnt, pers_m;
   logic              thr_set, out_win, hw_off;
   pic_pkg::pic_seq_t seq, next_seq;
   logic [15:0]       ph_cnt, next_ph_cnt, ph_len, ir_val, next_ir_val;
   logic [15:0]       prox_val, next_prox_val, res_val;
   logic [7:0]        mod_cnt, next_mod_cnt;
   logic              mod_lvl, next_mod_lvl, led, next_led;
   logic [2:0]        osc_s, next_osc_s;
   logic              osc_lvl, next_osc_lvl, osc_rise, cyc_end;
   logic              mode_valid, is_prox, is_once;

   // Readiness drops with the clock enable so no beat is taken while state is frozen.
   assign awready = ce && !aw_hold && !bvalid_q;
   assign wready  = ce && !w_hold && !bvalid_q;
   assign arready = ce && !rvalid_q;
   assign bvalid  = bvalid_q;
   assign bresp   = bresp_q;
   assign rvalid  = rvalid_q;
   assign rresp   = rresp_q;
   assign rdata   = rdata_q;
   assign wr_do   = ce && aw_hold && w_hold && !bvalid_q;
   assign wr_ok   = wr_do && w_lane;
   assign wr_cmd1 = wr_ok && (aw_idx == pic_pkg::IDX_CMD1);
   assign mode_wr_chg = wr_cmd1 && (w_byte[7:5] != cmd1.mode);

   always_comb begin
      case (araddr[7:2])
         pic_pkg::IDX_CMD1: rd_val = {cmd1.mode, 2'b00, cmd1.flag, cmd1.persist};
         pic_pkg::IDX_CMD2: rd_val = cmd2;
         pic_pkg::IDX_DLSB: rd_val = data[7:0];
         pic_pkg::IDX_DMSB: rd_val = data[15:8];
         pic_pkg::IDX_LTL:  rd_val = lt[7:0];
         pic_pkg::IDX_LTM:  rd_val = lt[15:8];
         pic_pkg::IDX_HTL:  rd_val = ht[7:0];
         pic_pkg::IDX_HTM:  rd_val = ht[15:8];
         pic_pkg::IDX_STAT: rd_val = {6'b00_0000, stat};
         pic_pkg::IDX_EN:   rd_val = {6'b00_0000, en};
         pic_pkg::IDX_ADDR: rd_val = {1'b0, pic_pkg::BUS_ADDR};
         default:           rd_val = 8'h00;
      endcase
   end

   always_comb begin
      next_aw_hold = aw_hold;
      next_aw_idx  = aw_idx;
      next_w_hold  = w_hold;
      next_w_byte  = w_byte;
      next_w_lane  = w_lane;
      next_bvalid  = bvalid_q;
      next_bresp   = bresp_q;
      next_rvalid  = rvalid_q;
      next_rdata   = rdata_q;
      next_rresp   = rresp_q;
      next_rd_idx  = rd_idx;
      if (awvalid && awready) begin
         next_aw_hold = 1'b1;
         next_aw_idx  = awaddr[7:2];
      end
      if (wvalid && wready) begin
         next_w_hold = 1'b1;
         next_w_byte = wdata[7:0];
         next_w_lane = wstrb[0];
      end
      if (wr_do) begin
         next_aw_hold = 1'b0;
         next_w_hold  = 1'b0;
         next_bvalid  = 1'b1;
         next_bresp   = (aw_idx > pic_pkg::IDX_ADDR) ? pic_pkg::RESP_ERR : pic_pkg::RESP_OK;
      end else if (bvalid_q && bready && ce) begin
         next_bvalid = 1'b0;
      end
      if (arvalid && arready) begin
         next_rvalid = 1'b1;
         next_rdata  = {24'h00_0000, rd_val};
         next_rd_idx = araddr[7:2];
         next_rresp  = (araddr[7:2] > pic_pkg::IDX_ADDR) ? pic_pkg::RESP_ERR : pic_pkg::RESP_OK;
      end else if (rvalid_q && rready && ce) begin
         next_rvalid = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold  <= 1'b0;
         aw_idx   <= 6'h00;
         w_hold   <= 1'b0;
         w_byte   <= 8'h00;
         w_lane   <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q  <= 2'h0;
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h0000_0000;
         rresp_q  <= 2'h0;
         rd_idx   <= 6'h00;
      end else if (ce) begin
         aw_hold  <= next_aw_hold;
         aw_idx   <= next_aw_idx;
         w_hold   <= next_w_hold;
         w_byte   <= next_w_byte;
         w_lane   <= next_w_lane;
         bvalid_q <= next_bvalid;
         bresp_q  <= next_bresp;
         rvalid_q <= next_rvalid;
         rdata_q  <= next_rdata;
         rresp_q  <= next_rresp;
         rd_idx   <= next_rd_idx;
      end
   end

   always_comb begin
      case (cmd1.persist)
         2'b00:   pers_m = pic_pkg::PERS_1;
         2'b01:   pers_m = pic_pkg::PERS_4;
         2'b10:   pers_m = pic_pkg::PERS_8;
         default: pers_m = pic_pkg::PERS_16;
      endcase
   end

   always_comb begin
      next_cmd1 = cmd1;
      next_cmd2 = cmd2;
      next_lt   = lt;
      next_ht   = ht;
      next_data = data;
      next_stat = stat;
      next_en   = en;
      next_pcnt = pcnt;
      thr_set   = 1'b0;
      out_win   = (res_val < lt) || (res_val > ht);
      hw_off    = cyc_end && is_once;
      if (cyc_end) begin
         next_data = res_val;
         if (out_win) begin
            if (5'(pcnt + 5'h01) >= pers_m) begin
               thr_set = 1'b1;
            end else begin
               next_pcnt = 5'(pcnt + 5'h01);
            end
         end else begin
            next_pcnt = 5'h00;
         end
      end
      if (hw_off) begin
         next_cmd1.mode = pic_pkg::MODE_OFF;
      end
      if (wr_ok) begin
         case (aw_idx)
            pic_pkg::IDX_CMD1: begin
               next_cmd1.mode    = w_byte[7:5];
               next_cmd1.persist = w_byte[1:0];
            end
            pic_pkg::IDX_CMD2: next_cmd2 = w_byte;
            pic_pkg::IDX_LTL:  next_lt[7:0] = w_byte;
            pic_pkg::IDX_LTM:  next_lt[15:8] = w_byte;
            pic_pkg::IDX_HTL:  next_ht[7:0] = w_byte;
            pic_pkg::IDX_HTM:  next_ht[15:8] = w_byte;
            pic_pkg::IDX_CLR:  next_stat = stat & ~w_byte[1:0];
            pic_pkg::IDX_EN:   next_en = w_byte[1:0];
            default:           next_en = en;
         endcase
      end
      if (wr_cmd1) begin
         next_cmd1.flag = 1'b0;
      end
      if (thr_set) begin
         next_cmd1.flag = 1'b1;
         next_stat[pic_pkg::STAT_THR] = 1'b1;
      end
      if (cyc_end) begin
         next_stat[pic_pkg::STAT_DONE] = 1'b1;
      end
      if (next_cmd1.mode != cmd1.mode) begin
         next_pcnt = 5'h00;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cmd1 <= '0;
         cmd2 <= '0;
         lt   <= {pic_pkg::RST_LT, pic_pkg::RST_LT};
         ht   <= {pic_pkg::RST_HT, pic_pkg::RST_HT};
         data <= 16'h0000;
         stat <= 2'b00;
         en   <= 2'b00;
         pcnt <= 5'h00;
      end else if (ce) begin
         cmd1 <= next_cmd1;
         cmd2 <= next_cmd2;
         lt   <= next_lt;
         ht   <= next_ht;
         data <= next_data;
         stat <= next_stat;
         en   <= next_en;
         pcnt <= next_pcnt;
      end
   end

   assign is_prox = (cmd1.mode == pic_pkg::MODE_PX1) || (cmd1.mode == pic_pkg::MODE_PXC);
   assign is_once = (cmd1.mode == pic_pkg::MODE_IR1) || (cmd1.mode == pic_pkg::MODE_PX1);
   assign mode_valid = is_prox || is_once || (cmd1.mode == pic_pkg::MODE_IRC);
   assign res_val = is_prox ? prox_val : ir_val;
   // The oscillator is sampled, so it must stay well below half the bus clock rate.
   assign osc_rise = (osc_s[1] == osc_s[2]) && osc_s[2] && !osc_lvl;

   always_comb begin
      case (cmd2.res)
         2'b00:   ph_len = pic_pkg::LEN_16;
         2'b01:   ph_len = pic_pkg::LEN_12;
         2'b10:   ph_len = pic_pkg::LEN_8;
         default: ph_len = pic_pkg::LEN_4;
      endcase
   end

   always_comb begin
      next_osc_s    = {osc_s[1:0], osc_clk};
      next_osc_lvl  = (osc_s[1] == osc_s[2]) ? osc_s[2] : osc_lvl;
      next_seq      = seq;
      next_ph_cnt   = ph_cnt;
      next_ir_val   = ir_val;
      next_prox_val = prox_val;
      cyc_end       = 1'b0;
      case (seq)
         pic_pkg::SEQ_IDLE: begin
            next_ph_cnt = 16'h0000;
            if (mode_valid) begin
               next_seq = pic_pkg::SEQ_IR1;
            end
         end
         pic_pkg::SEQ_IR1, pic_pkg::SEQ_PROX, pic_pkg::SEQ_IR2: begin
            if (osc_rise && ph_cnt == ph_len) begin
               next_ph_cnt = 16'h0000;
               if (seq == pic_pkg::SEQ_IR1) begin
                  next_ir_val = adc_code;
                  next_seq    = pic_pkg::SEQ_PROX;
               end else if (seq == pic_pkg::SEQ_PROX) begin
                  next_prox_val = adc_code;
                  next_seq      = pic_pkg::SEQ_IR2;
               end else begin
                  cyc_end  = 1'b1;
                  next_seq = pic_pkg::SEQ_IDLE;
               end
            end else if (osc_rise) begin
               next_ph_cnt = 16'(ph_cnt + 16'h0001);
            end
         end
         default: next_seq = pic_pkg::SEQ_IDLE;
      endcase
      // A mode change or reserved code abandons the cycle rather than mixing readings.
      if (mode_wr_chg || !mode_valid) begin
         next_seq = pic_pkg::SEQ_IDLE;
         cyc_end  = 1'b0;
      end
      next_mod_cnt = 8'h00;
      next_mod_lvl = 1'b1;
      if (seq == pic_pkg::SEQ_PROX) begin
         next_mod_lvl = mod_lvl;
         if (mod_cnt == pic_pkg::MOD_HALF) begin
            next_mod_lvl = !mod_lvl;
         end else begin
            next_mod_cnt = 8'(mod_cnt + 8'h01);
         end
      end
      next_led = (seq == pic_pkg::SEQ_PROX) && is_prox && (!cmd2.mod_en || mod_lvl);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         osc_s    <= 3'b000;
         osc_lvl  <= 1'b0;
         seq      <= pic_pkg::SEQ_IDLE;
         ph_cnt   <= 16'h0000;
         ir_val   <= 16'h0000;
         prox_val <= 16'h0000;
         mod_cnt  <= 8'h00;
         mod_lvl  <= 1'b1;
         led      <= 1'b0;
      end else if (ce) begin
         osc_s    <= next_osc_s;
         osc_lvl  <= next_osc_lvl;
         seq      <= next_seq;
         ph_cnt   <= next_ph_cnt;
         ir_val   <= next_ir_val;
         prox_val <= next_prox_val;
         mod_cnt  <= next_mod_cnt;
         mod_lvl  <= next_mod_lvl;
         led      <= next_led;
      end
   end

   assign led_drive_output = led;
   assign led_current_sel  = cmd2.current;
   assign adc_resolution   = cmd2.res;
   assign adc_range        = cmd2.range;
   assign adc_integrate    = (seq != pic_pkg::SEQ_IDLE);
   assign adc_prox_phase   = (seq == pic_pkg::SEQ_PROX) && is_prox;
   assign int_n_o          = 1'b0;
   assign int_n_oe         = cmd1.flag;
   assign irq              = |(stat & en);

   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_ir1_done;
      ce && seq == pic_pkg::SEQ_IR1 && next_seq != pic_pkg::SEQ_IR1;
   endsequence
   sequence s_cmd2_write;
      ce && wr_ok && aw_idx == pic_pkg::IDX_CMD2;
   endsequence

   led_prox_only_a: assert property (led |-> $past(seq) == pic_pkg::SEQ_PROX && $past(is_prox))
      else $error("LED driven outside the proximity phase.");
   led_dc_a: assert property ((ce && seq == pic_pkg::SEQ_PROX && is_prox && !cmd2.mod_en)[*2] |-> led)
      else $error("LED not steady in DC mode.");
   mod_toggle_a: assert property (ce && seq == pic_pkg::SEQ_PROX && mod_cnt == pic_pkg::MOD_HALF |=> mod_lvl != $past(mod_lvl))
      else $error("Modulation did not toggle after a half period.");
   current_sel_a: assert property (s_cmd2_write |=> led_current_sel == $past(w_byte[5:4]))
      else $error("LED current select does not follow the write.");
   phase_order_a: assert property (s_ir1_done |=> seq == pic_pkg::SEQ_PROX || seq == pic_pkg::SEQ_IDLE)
      else $error("Proximity phase did not follow the first IR phase.");
   persist_clear_a: assert property (ce && mode_wr_chg |=> pcnt == 5'h00)
      else $error("Mode change left the persistence counter set.");
   flag_clear_a: assert property (ce && wr_cmd1 && !thr_set |=> !cmd1.flag && !int_n_oe)
      else $error("Flag not cleared by the command register write.");
   flag_hold_a: assert property (cmd1.flag && !wr_cmd1 |=> cmd1.flag)
      else $error("Flag dropped without a command register write.");
   flag_set_a: assert property (ce && thr_set |-> cyc_end && out_win && 5'(pcnt + 5'h01) >= pers_m ##1 cmd1.flag)
      else $error("Flag set without enough out-of-window cycles.");
   bus_addr_a: assert property (rvalid && rd_idx == pic_pkg::IDX_ADDR |-> rdata[6:0] == pic_pkg::BUS_ADDR)
      else $error("Bus address readback is wrong.");
   // A single-shot cycle drops the mode in the same edge, so the phase choice is taken from before it.
   result_sel_a: assert property (ce && cyc_end |=>
      data == ($past(is_prox) ? $past(prox_val) : $past(ir_val)))
      else $error("Result taken from the wrong phase.");
   once_off_a: assert property (ce && cyc_end && is_once && !wr_cmd1 |=> cmd1.mode == pic_pkg::MODE_OFF)
      else $error("Single-shot mode did not return to power-down.");
   reserved_idle_a: assert property (ce && !mode_valid |=> seq == pic_pkg::SEQ_IDLE)
      else $error("Sequencer ran in a reserved mode.");
   reset_thr_a: assert property ($rose(aresetn) |-> lt == 16'h0000 && ht == 16'hFFFF)
      else $error("Threshold reset values are wrong.");
endmodule

// file: pic_sensor_model.sv
module pic_sensor_model (
   output logic             osc_clk,
   output logic [15:0]      adc_code,
   input  wire logic        adc_prox_phase,
   input  wire logic [15:0] level
);
   timeunit 1ns;
   timeprecision 1ps;
   // The sensor oscillator runs freely, out of phase with the bus clock, as a real one would.
   initial begin
      osc_clk = 1'b0;
      #13;
      forever #40 osc_clk = ~osc_clk;
   end
   // The infrared phases read a fixed step above the proximity phase, so a result taken
   // from the wrong phase shows in both the data registers and the threshold outcome.
   assign adc_code = adc_prox_phase ? level : 16'(level + 16'h0100);
endmodule

// file: test_proximity_interrupt_control.sv
module test_proximity_interrupt_control;
   timeunit 1ns;
   timeprecision 1ps;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic        ce = 1'b1;
   logic [7:0]  awaddr = 8'h00;
   logic        awvalid = 1'b0;
   logic        awready;
   logic [31:0] wdata = 32'h0000_0000;
   logic [3:0]  wstrb = 4'h0;
   logic        wvalid = 1'b0;
   logic        wready;
   logic [1:0]  bresp;
   logic        bvalid;
   logic        bready = 1'b0;
   logic [7:0]  araddr = 8'h00;
   logic        arvalid = 1'b0;
   logic        arready;
   logic [31:0] rdata;
   logic [1:0]  rresp;
   logic        rvalid;
   logic        rready = 1'b0;
   logic        osc_clk;
   logic [15:0] adc_code;
   logic [15:0] level = 16'h0005;
   logic        led_drive_output;
   logic [1:0]  led_current_sel;
   logic [1:0]  adc_resolution;
   logic [1:0]  adc_range;
   logic        int_n_o;
   logic        adc_integrate;
   logic        adc_prox_phase;
   logic        int_n_oe;
   logic        irq;
   logic        prev_prox = 1'b0;
   logic [1:0]  rs;
   int          err_total = 0;
   int          n_compared = 0;

`define CHK(act, exp) begin n_compared++; if ((act) !== (exp)) begin err_total++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (act), (exp)); end end

   always #4 aclk = ~aclk;

   pic_sensor_model u_pic_sensor_model (.osc_clk, .adc_code, .adc_prox_phase, .level);

   pic_top u_pic_top (
      .aclk, .aresetn, .ce, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
      .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
      .osc_clk, .adc_code, .led_drive_output, .led_current_sel, .adc_resolution,
      .adc_range, .adc_integrate, .adc_prox_phase, .int_n_o, .int_n_oe, .irq
   );

   // The LED output lags the phase by one register, so the previous phase value is allowed.
   always @(posedge aclk) begin
      if (aresetn && led_drive_output === 1'b1) `CHK(adc_prox_phase | prev_prox, 1'b1)
      prev_prox = adc_prox_phase;
   end

   task automatic wr(input logic [5:0] idx, input logic [7:0] d, input logic [1:0] er);
      @(posedge aclk);
      awaddr  <= {idx, 2'b00};
      wdata   <= {24'h00_0000, d};
      wstrb   <= 4'hF;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      @(posedge aclk);
      while (awvalid || wvalid || bvalid !== 1'b1) begin
         if (awvalid && awready === 1'b1) awvalid <= 1'b0;
         if (wvalid && wready === 1'b1) wvalid <= 1'b0;
         @(posedge aclk);
      end
      bready <= 1'b0;
      `CHK(bresp, er)
   endtask

   task automatic rd_chk(input logic [5:0] idx, input logic [7:0] exp);
      @(posedge aclk);
      araddr  <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready  <= 1'b1;
      @(posedge aclk);
      while (arvalid || rvalid !== 1'b1) begin
         if (arvalid && arready === 1'b1) arvalid <= 1'b0;
         @(posedge aclk);
      end
      rready <= 1'b0;
      rs = rresp;
      `CHK(rdata, {24'h00_0000, exp})
   endtask

   task automatic t_map;
      rd_chk(pic_pkg::IDX_CMD1, 8'h00);
      rd_chk(pic_pkg::IDX_LTL, 8'h00);
      rd_chk(pic_pkg::IDX_LTM, 8'h00);
      rd_chk(pic_pkg::IDX_HTL, 8'hFF);
      rd_chk(pic_pkg::IDX_HTM, 8'hFF);
      wr(pic_pkg::IDX_ADDR, 8'h12, 2'h0);
      rd_chk(pic_pkg::IDX_ADDR, 8'h44);
      wr(6'h0C, 8'h33, 2'h2);
      rd_chk(6'h0C, 8'h00);
      `CHK(rs, 2'h2)
      wr(pic_pkg::IDX_HTL, 8'h5A, 2'h0);
      rd_chk(pic_pkg::IDX_HTL, 8'h5A);
      wr(pic_pkg::IDX_HTL, 8'hFF, 2'h0);
   endtask

   task automatic t_prox_once;
      wr(pic_pkg::IDX_CMD2, 8'h2D, 2'h0);
      `CHK(led_current_sel, 2'b10)
      `CHK(adc_resolution, 2'b11)
      `CHK(adc_range, 2'b01)
      wr(pic_pkg::IDX_EN, 8'h03, 2'h0);
      wr(pic_pkg::IDX_CMD1, 8'h60, 2'h0);
      wr(pic_pkg::IDX_LTL, 8'h10, 2'h0);
      while (adc_prox_phase !== 1'b1) @(posedge aclk);
      repeat (40) @(posedge aclk);
      `CHK(led_drive_output, 1'b1)
      while (irq !== 1'b1) @(posedge aclk);
      `CHK(int_n_oe, 1'b1)
      `CHK(int_n_o, 1'b0)
      rd_chk(pic_pkg::IDX_CMD1, 8'h04);
      rd_chk(pic_pkg::IDX_DLSB, 8'h05);
      rd_chk(pic_pkg::IDX_DMSB, 8'h00);
      wr(pic_pkg::IDX_EN, 8'h00, 2'h0);
      `CHK(irq, 1'b0)
      wr(pic_pkg::IDX_CLR, 8'h03, 2'h0);
      rd_chk(pic_pkg::IDX_STAT, 8'h00);
      `CHK(int_n_oe, 1'b1)
      wr(pic_pkg::IDX_CMD1, 8'h00, 2'h0);
      `CHK(int_n_oe, 1'b0)
      rd_chk(pic_pkg::IDX_CMD1, 8'h00);
   endtask

   task automatic t_ir_once;
      wr(pic_pkg::IDX_LTL, 8'h10, 2'h0);
      wr(pic_pkg::IDX_EN, 8'h02, 2'h0);
      wr(pic_pkg::IDX_CMD1, 8'h40, 2'h0);
      // Freeze the sequencer briefly; the bus must refuse while the enable is low.
      @(posedge aclk);
      ce <= 1'b0;
      repeat (3) @(posedge aclk);
      `CHK(awready, 1'b0)
      `CHK(adc_integrate, 1'b1)
      ce <= 1'b1;
      while (irq !== 1'b1) @(posedge aclk);
      `CHK(int_n_oe, 1'b0)
      rd_chk(pic_pkg::IDX_CMD1, 8'h00);
      rd_chk(pic_pkg::IDX_DLSB, 8'h05);
      rd_chk(pic_pkg::IDX_DMSB, 8'h01);
      wr(pic_pkg::IDX_CLR, 8'h03, 2'h0);
      `CHK(irq, 1'b0)
   endtask

   task automatic t_reserved;
      logic [2:0] codes [3] = '{3'b001, 3'b100, 3'b101};
      logic       hit;
      for (int i = 0; i < 3; i++) begin
         hit = 1'b0;
         wr(pic_pkg::IDX_CMD1, {codes[i], 5'h00}, 2'h0);
         repeat (600) begin
            @(posedge aclk);
            if (adc_integrate === 1'b1) hit = 1'b1;
         end
         `CHK(hit, 1'b0)
      end
      wr(pic_pkg::IDX_CMD1, 8'h00, 2'h0);
   endtask

   task automatic t_modulate;
      int n;
      for (int c = 0; c < 4; c++) begin
         wr(pic_pkg::IDX_CMD2, {2'b00, 2'(c), 4'h0}, 2'h0);
         `CHK(led_current_sel, 2'(c))
      end
      n = 0;
      wr(pic_pkg::IDX_CMD2, 8'h68, 2'h0);
      wr(pic_pkg::IDX_CMD1, 8'hE0, 2'h0);
      while (led_drive_output !== 1'b1) @(posedge aclk);
      while (led_drive_output !== 1'b0) @(posedge aclk);
      while (led_drive_output !== 1'b1) @(posedge aclk);
      while (led_drive_output === 1'b1) begin
         n++;
         @(posedge aclk);
      end
      `CHK(n, pic_pkg::CLK_KHZ / (2 * pic_pkg::MOD_KHZ))
      wr(pic_pkg::IDX_CMD1, 8'h00, 2'h0);
   endtask

   task automatic print_verdict;
      if (err_total == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // Cuts a hang short; the full sequence needs well under a fifth of this span.
   initial begin
      #400us;
      err_total++;
      print_verdict();
   end

   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      t_map();
      t_prox_once();
      t_ir_once();
      t_reserved();
      t_modulate();
      print_verdict();
   end
endmodule
